// >>> design/fdc_core.sv
// Floating-point signal processor core with its AXI4-Lite register slave.
// Behaviour
// - Multiplier forms product every cycle, unasked.
// - Product readable as low or high 32 bits.
// - 24x24 mantissa multiplier plus exponent adder.
// - Both multiplier operands written and read.
// - 47-bit barrel shifter, both directions.
// - Flags into one of two words.
// - Results land in eight 55-bit accumulators.
// - Operand source select for P ALU input; Q from accumulators.
// - RAM sub-bus loads multiplier operands in parallel.
// - RAM addressed by base, index or sum.
// - Pointer step, clear, modulo, index plus base.
// - Counting touches only low ten bits.
// - Count past zero skips next instruction.
// - Three-stage pipeline, one instruction per cycle.
// - Program store sits in top 2K words.
// - 24-bit pointer addresses external data RAM.
// - Maskable and nonmaskable interrupts; maskable latched.
// - Interrupt state read back, changed by instructions.
// - Status write drives outputs; branches sample inputs.
// - 22-bit status word layout; the status register here uses only bits 0 to 5.
// - 32-bit configuration word, saved and restored.
// - Maskable falling edge vectors to 8H.
// - Nonmaskable falling edge vectors to 4H.
// - Output pins at status bits 2 and 3.
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps

module fdc_core #(
  parameter int RAM_DEPTH = 512,
  parameter int PS_DEPTH  = 2048
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic [15:0]      instr_addr,
  input  wire logic [31:0] instr_data,
  output logic [23:0]      ext_addr,
  input  wire logic [31:0] ext_din,
  output logic [31:0]      ext_dout,
  output logic             ext_oe_n,
  output logic             ext_re_n,
  output logic             ext_we_n,
  input  wire logic        int_n,
  input  wire logic        nmi_n,
  input  wire logic [1:0]  gp_in,
  output logic [1:0]       gp_out
);

  logic        run;
  logic [31:0] k_op;
  logic [31:0] l_op;
  logic [31:0] cnt;
  logic [31:0] cfg;
  logic [31:0] main_d;
  logic [54:0] prod;
  logic [54:0] p_r;
  logic [54:0] q_r;
  logic [54:0] p_in;
  logic [54:0] q_in;
  logic [54:0] res;
  logic [54:0] acc [8];
  logic [31:0] ram [2][RAM_DEPTH];
  logic [31:0] pstore [PS_DEPTH];
  logic [8:0]  base [2];
  logic [8:0]  idx [2];
  logic [8:0]  ra [2];
  logic [31:0] rd [2];
  logic [3:0]  fl [2];
  logic [10:0] ps_addr;
  logic [31:0] ps_q;
  logic        f_ps;
  logic        f_val;
  logic        e_val;
  logic [15:0] f_pc;
  logic [15:0] ret_pc;
  logic [31:0] e_w;
  logic [31:0] id_w;
  logic [2:0]  asel;
  logic [1:0]  int_s;
  logic [1:0]  nmi_s;
  logic [1:0]  gp_m;
  logic [1:0]  gp_s;
  logic        int_d;
  logic        nmi_d;
  logic        ie;
  logic        int_lat;
  logic        nmi_pend;
  logic        err;
  logic        done;
  logic [3:0]  fn;
  logic        is_br;
  logic        br_take;
  logic        ctl;
  logic        is_alu;
  logic        skip;
  logic        nmi_go;
  logic        int_go;
  logic        redir;
  logic [15:0] tgt;
  logic [46:0] pm;
  logic [46:0] qm;
  logic [7:0]  pe;
  logic [7:0]  qe;
  logic        sub;
  logic [46:0] b_x;
  logic [47:0] s48;
  logic        carry;
  logic        ovf;
  logic [8:0]  ed;
  logic [8:0]  mag;
  logic [5:0]  shamt;
  logic [46:0] big_m;
  logic [46:0] sm_m;
  logic [7:0]  big_e;
  logic [47:0] fs;
  logic        fovf;
  logic        we;
  logic        re;
  logic [47:0] mp;
  logic [31:0] rmux;

  function automatic logic [54:0] widen(logic [31:0] x);
    return {x, {(fdc_pkg::WW - fdc_pkg::XW){1'b0}}};
  endfunction : widen

  // Bidirectional mantissa shifter; right shifts keep the sign.
  function automatic logic [46:0] shf(logic [46:0] v, logic [5:0] n, logic lft);
    logic [46:0] r;
    r = lft ? v << n : $signed(v) >>> n;
    return r;
  endfunction : shf

  // A nonzero length confines stepping to the low bits, a ring of 2^n words.
  function automatic logic [8:0] step(logic [8:0] b, logic [3:0] n, logic dn);
    logic [8:0] m;
    logic [8:0] s;
    m = (n == 4'h0) ? 9'h1ff : 9'((16'h1 << n) - 16'h1);
    s = dn ? b - 9'h1 : b + 9'h1;
    return (b & ~m) | (s & m);
  endfunction : step

  function automatic logic [31:0] bm(logic [31:0] o, logic [31:0] d, logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i +: 8] = d[8*i +: 8];
    end
    return o;
  endfunction : bm

  function automatic logic wh(logic [7:0] a);
    return we && (awaddr[7:2] == a[7:2]);
  endfunction : wh

  assign we = awready & awvalid & wvalid;
  assign re = arready & arvalid;

  // AXI write channel: address and data are taken together in one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= fdc_pkg::RESP_OK;
    end else begin
      awready <= ~awready & awvalid & wvalid & ~bvalid;
      wready  <= ~awready & awvalid & wvalid & ~bvalid;
      if (we) begin
        bvalid <= 1'b1;
        bresp  <= (awaddr[7:2] <= fdc_pkg::A_PC[7:2]) ? fdc_pkg::RESP_OK : fdc_pkg::RESP_ERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    case (araddr[7:2])
      fdc_pkg::A_RUN[7:2]:  rmux = {31'h0, run};
      fdc_pkg::A_STAT[7:2]: rmux = 32'({done, err, gp_out, int_lat, ie});
      fdc_pkg::A_CFG[7:2]:  rmux = cfg;
      fdc_pkg::A_CNT[7:2]:  rmux = cnt;
      fdc_pkg::A_K[7:2]:    rmux = k_op;
      fdc_pkg::A_L[7:2]:    rmux = l_op;
      fdc_pkg::A_PRD[7:2]:  rmux = cfg[fdc_pkg::CF_MV] ? prod[31:0] : prod[54:23];
      fdc_pkg::A_MAIN[7:2]: rmux = main_d;
      fdc_pkg::A_EPT[7:2]:  rmux = 32'(ext_addr);
      fdc_pkg::A_FLG[7:2]:  rmux = 32'({fl[1], fl[0]});
      fdc_pkg::A_PTR0[7:2]: rmux = {7'h0, idx[0], 7'h0, base[0]};
      fdc_pkg::A_PTR1[7:2]: rmux = {7'h0, idx[1], 7'h0, base[1]};
      fdc_pkg::A_PSA[7:2]:  rmux = 32'(ps_addr);
      fdc_pkg::A_ASEL[7:2]: rmux = 32'(asel);
      fdc_pkg::A_ACCL[7:2]: rmux = acc[asel][31:0];
      fdc_pkg::A_ACCH[7:2]: rmux = 32'(acc[asel][54:32]);
      fdc_pkg::A_PC[7:2]:   rmux = {ret_pc, instr_addr};
      default:              rmux = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= fdc_pkg::RESP_OK;
    end else begin
      arready <= ~arready & arvalid & ~rvalid;
      if (re) begin
        rvalid <= 1'b1;
        rdata  <= rmux;
        rresp  <= (araddr[7:2] <= fdc_pkg::A_PC[7:2]) ? fdc_pkg::RESP_OK : fdc_pkg::RESP_ERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Software loads the program store while the core is halted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run     <= 1'b0;
      ps_addr <= 11'h0;
      asel    <= 3'h0;
    end else begin
      if (wh(fdc_pkg::A_RUN) && wstrb[0]) run <= wdata[0];
      if (wh(fdc_pkg::A_ASEL) && wstrb[0]) asel <= wdata[2:0];
      if (wh(fdc_pkg::A_PSA)) ps_addr <= wdata[10:0];
      else if (wh(fdc_pkg::A_PSD)) ps_addr <= ps_addr + 11'h1;
    end
  end

  always_ff @(posedge aclk) begin
    if (wh(fdc_pkg::A_PSD)) pstore[ps_addr] <= wdata;
    ps_q <= pstore[instr_addr[fdc_pkg::PAW-1:0]];
  end

  // Pins from outside pass two flops before edge detection reads them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_s <= 2'h3;
      nmi_s <= 2'h3;
      gp_m  <= 2'h0;
      gp_s  <= 2'h0;
      int_d <= 1'b1;
      nmi_d <= 1'b1;
    end else begin
      int_s <= {int_s[0], int_n};
      nmi_s <= {nmi_s[0], nmi_n};
      gp_m  <= gp_in;
      gp_s  <= gp_m;
      int_d <= int_s[1];
      nmi_d <= nmi_s[1];
    end
  end

  assign fn      = e_w[fdc_pkg::IF_FN +: 4];
  assign is_br   = e_val && (fn == fdc_pkg::FN_BR);
  assign ctl     = e_val && !is_br;
  assign is_alu  = ctl && (fn != fdc_pkg::FN_NOP) && (fn <= fdc_pkg::FN_ADDF);
  assign br_take = is_br && (gp_s[e_w[fdc_pkg::IF_BG]] == e_w[fdc_pkg::IF_BV]);
  assign skip    = ctl && e_w[fdc_pkg::IF_LD] && (cnt[fdc_pkg::CW-1:0] == 10'h0);
  assign nmi_go  = run && nmi_pend && !br_take && !skip;
  assign int_go  = run && ie && int_lat && !nmi_go && !br_take && !skip;
  assign redir   = br_take || nmi_go || int_go;
  assign tgt     = nmi_go ? fdc_pkg::VEC_NMI : int_go ? fdc_pkg::VEC_INT : e_w[15:0];
  assign id_w    = f_ps ? ps_q : instr_data;

  // Fetch, operand and execute stages advance together every cycle while run is set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_addr <= 16'h0;
      f_pc       <= 16'h0;
      f_ps       <= 1'b0;
      f_val      <= 1'b0;
      e_val      <= 1'b0;
      e_w        <= 32'h0;
    end else if (!run) begin
      f_val <= 1'b0;
      e_val <= 1'b0;
    end else begin
      instr_addr <= redir ? tgt : instr_addr + 16'h1;
      f_pc       <= instr_addr;
      f_ps       <= instr_addr[15:11] == fdc_pkg::PS_TOP;
      f_val      <= !redir;
      e_val      <= f_val && !redir && !skip;
      e_w        <= id_w;
    end
  end

  // Forwarding hides the one-cycle gap between execute and operand stages.
  always_comb begin
    q_in = acc[id_w[fdc_pkg::IF_Q +: 3]];
    if (is_alu && e_w[fdc_pkg::IF_Q +: 3] == id_w[fdc_pkg::IF_Q +: 3]) q_in = res;
    case (id_w[fdc_pkg::IF_PS +: 3])
      fdc_pkg::PS_WIDE: p_in = (is_alu && e_w[fdc_pkg::IF_Q +: 3] == id_w[2:0]) ? res
                               : acc[id_w[2:0]];
      fdc_pkg::PS_MAIN: p_in = widen(main_d);
      fdc_pkg::PS_RAM0: p_in = widen(rd[0]);
      fdc_pkg::PS_RAM1: p_in = widen(rd[1]);
      fdc_pkg::PS_PROD: p_in = prod;
      default:          p_in = 55'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_r <= 55'h0;
      q_r <= 55'h0;
    end else begin
      p_r <= p_in;
      q_r <= q_in;
    end
  end

  // The product is formed every cycle, so no instruction ever asks for it.
  assign mp = $signed(k_op[fdc_pkg::FW-1:0]) * $signed(l_op[fdc_pkg::FW-1:0]);
  always_ff @(posedge aclk) begin
    if (!aresetn) prod <= 55'h0;
    else prod <= {cfg[fdc_pkg::CF_FIX] ? 8'h00 : k_op[31:24] + l_op[31:24],
                  mp[fdc_pkg::MW-1:0]};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      k_op <= 32'h0;
      l_op <= 32'h0;
    end else begin
      if (ctl && e_w[fdc_pkg::IF_KL]) begin
        k_op <= rd[0];
        l_op <= rd[1];
      end
      if (wh(fdc_pkg::A_K)) k_op <= bm(k_op, wdata, wstrb);
      if (wh(fdc_pkg::A_L)) l_op <= bm(l_op, wdata, wstrb);
    end
  end

  assign {pe, pm} = p_r;
  assign {qe, qm} = q_r;
  assign sub   = (fn == fdc_pkg::FN_SUB) || (fn == fdc_pkg::FN_DEC);
  assign b_x   = ((fn == fdc_pkg::FN_INC) || (fn == fdc_pkg::FN_DEC)) ? {46'h0, !sub}
                 | {47{sub}} & ~47'h1 : (sub ? ~pm : pm);
  assign s48   = {1'b0, qm} + {1'b0, b_x} + {47'h0, sub};
  assign carry = s48[fdc_pkg::MW];
  assign ovf   = (qm[46] == b_x[46]) && (s48[46] != qm[46]);
  // Exponent unit: the difference sets the alignment shift of the smaller one.
  assign ed    = {pe[7], pe} - {qe[7], qe};
  assign mag   = ed[8] ? 9'h0 - ed : ed;
  assign shamt = (|mag[8:6]) ? 6'h3f : mag[5:0];
  assign big_m = ed[8] ? qm : pm;
  assign big_e = ed[8] ? qe : pe;
  assign sm_m  = shf(ed[8] ? pm : qm, shamt, 1'b0);
  assign fs    = {big_m[46], big_m} + {sm_m[46], sm_m};
  assign fovf  = fs[47] ^ fs[46];

  always_comb begin
    case (fn)
      fdc_pkg::FN_INC, fdc_pkg::FN_DEC,
      fdc_pkg::FN_ADD, fdc_pkg::FN_SUB: res = {8'h00, s48[46:0]};
      fdc_pkg::FN_NEG:  res = {8'h00, 47'h0 - qm};
      fdc_pkg::FN_NOT:  res = {qe, ~qm};
      fdc_pkg::FN_AND:  res = {qe, qm & pm};
      fdc_pkg::FN_OR:   res = {qe, qm | pm};
      fdc_pkg::FN_XOR:  res = {qe, qm ^ pm};
      fdc_pkg::FN_SHL:  res = {8'h00, shf(qm, cfg[fdc_pkg::CF_SHV +: 6], 1'b1)};
      fdc_pkg::FN_SHR:  res = {8'h00, shf(qm, cfg[fdc_pkg::CF_SHV +: 6], 1'b0)};
      fdc_pkg::FN_ADDF: res = fovf ? {big_e + 8'h1, fs[47:1]} : {big_e, fs[46:0]};
      default:          res = q_r;
    endcase
  end

  // Flags land in the word that the configuration currently selects.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) acc[i] <= 55'h0;
      fl[0] <= 4'h0;
      fl[1] <= 4'h0;
    end else if (is_alu) begin
      acc[e_w[fdc_pkg::IF_Q +: 3]] <= res;
      fl[cfg[fdc_pkg::CF_FSEL]] <= {(fn inside {[fdc_pkg::FN_INC:fdc_pkg::FN_DEC],
                                     [fdc_pkg::FN_ADD:fdc_pkg::FN_SUB]}) & carry,
                                    res[46:0] == 47'h0, res[46],
                                    (fn == fdc_pkg::FN_ADDF) ? fovf
                                    : (fn inside {fdc_pkg::FN_ADD, fdc_pkg::FN_SUB}) & ovf};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) cnt <= 32'h0;
    else begin
      if (ctl && e_w[fdc_pkg::IF_LD]) cnt[fdc_pkg::CW-1:0] <= cnt[fdc_pkg::CW-1:0] - 10'h1;
      if (wh(fdc_pkg::A_CNT)) cnt <= bm(cnt, wdata, wstrb);
    end
  end

  always_comb begin
    for (int j = 0; j < 2; j++) begin
      case (cfg[fdc_pkg::CF_M0 + 2*j +: 2])
        fdc_pkg::AM_IDX: ra[j] = idx[j];
        fdc_pkg::AM_SUM: ra[j] = base[j] + idx[j];
        default:         ra[j] = base[j];
      endcase
      rd[j] = ram[j][ra[j]];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int j = 0; j < 2; j++) begin
        base[j] <= 9'h0;
        idx[j]  <= 9'h0;
      end
    end else begin
      for (int j = 0; j < 2; j++) begin
        if (ctl) begin
          case (e_w[fdc_pkg::IF_P0 - 3*j +: 3])
            fdc_pkg::PT_BINC: base[j] <= step(base[j], cfg[fdc_pkg::CF_MOD0 + 4*j +: 4], 1'b0);
            fdc_pkg::PT_BDEC: base[j] <= step(base[j], cfg[fdc_pkg::CF_MOD0 + 4*j +: 4], 1'b1);
            fdc_pkg::PT_BCLR: base[j] <= 9'h0;
            fdc_pkg::PT_IINC: idx[j] <= idx[j] + 9'h1;
            fdc_pkg::PT_IDEC: idx[j] <= idx[j] - 9'h1;
            fdc_pkg::PT_ICLR: idx[j] <= 9'h0;
            fdc_pkg::PT_IADD: idx[j] <= idx[j] + base[j];
            default: ;
          endcase
        end
        if (we && awaddr[7:2] == fdc_pkg::A_PTR0[7:2] + 6'(j)) begin
          base[j] <= wdata[8:0];
          idx[j]  <= wdata[24:16];
        end
      end
    end
  end

  // A store writes the 32-bit view of the operand-stage accumulator.
  always_ff @(posedge aclk) begin
    for (int j = 0; j < 2; j++) begin
      if (ctl && e_w[fdc_pkg::IF_S0 - j]) ram[j][ra[j]] <= q_r[54:23];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) cfg <= fdc_pkg::CFG_RST;
    else begin
      if (ctl && e_w[fdc_pkg::IF_FT]) cfg[fdc_pkg::CF_FSEL] <= ~cfg[fdc_pkg::CF_FSEL];
      if (wh(fdc_pkg::A_CFG)) cfg <= bm(cfg, wdata, wstrb);
    end
  end

  // Interrupt state moves by instruction, pin edge and interrupt entry; software sees it read-only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ie       <= 1'b0;
      int_lat  <= 1'b0;
      nmi_pend <= 1'b0;
      ret_pc   <= 16'h0;
    end else begin
      if (ctl && e_w[fdc_pkg::IF_IC +: 2] == fdc_pkg::IC_EN) ie <= 1'b1;
      if (ctl && e_w[fdc_pkg::IF_IC +: 2] == fdc_pkg::IC_DIS) ie <= 1'b0;
      if (int_go) ie <= 1'b0;
      if (int_go || (ctl && e_w[fdc_pkg::IF_IC +: 2] == fdc_pkg::IC_DROP)) int_lat <= 1'b0;
      if (int_d && !int_s[1]) int_lat <= 1'b1;
      if (nmi_go) nmi_pend <= 1'b0;
      if (nmi_d && !nmi_s[1]) nmi_pend <= 1'b1;
      if (nmi_go || int_go) ret_pc <= f_val ? f_pc : instr_addr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gp_out <= 2'h0;
      err    <= 1'b0;
      done   <= 1'b0;
    end else begin
      if (wh(fdc_pkg::A_STAT) && wstrb[0]) begin
        gp_out <= wdata[fdc_pkg::ST_GP +: 2];
        if (wdata[fdc_pkg::ST_ERR]) err <= 1'b0;
        if (wdata[fdc_pkg::ST_DONE]) done <= 1'b0;
      end
      if (is_alu && (fn inside {fdc_pkg::FN_ADD, fdc_pkg::FN_SUB}) && ovf) err <= 1'b1;
      if (!ext_re_n) done <= 1'b1;
    end
  end

  // External strobes last one cycle; read data is taken as the strobe ends.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_addr <= 24'h0;
      ext_dout <= 32'h0;
      ext_oe_n <= 1'b1;
      ext_re_n <= 1'b1;
      ext_we_n <= 1'b1;
      main_d   <= 32'h0;
    end else begin
      ext_re_n <= !(ctl && e_w[fdc_pkg::IF_EX +: 2] == fdc_pkg::EX_RD);
      ext_we_n <= !(ctl && e_w[fdc_pkg::IF_EX +: 2] == fdc_pkg::EX_WR);
      ext_oe_n <= !(ctl && e_w[fdc_pkg::IF_EX +: 2] == fdc_pkg::EX_WR);
      if (ctl && e_w[fdc_pkg::IF_EX +: 2] == fdc_pkg::EX_WR) ext_dout <= main_d;
      if (ctl && e_w[fdc_pkg::IF_EX +: 2] == fdc_pkg::EX_INC) ext_addr <= ext_addr + 24'h1;
      if (wh(fdc_pkg::A_EPT)) ext_addr <= 24'(bm(32'(ext_addr), wdata, wstrb));
      if (!ext_re_n) main_d <= ext_din;
      if (wh(fdc_pkg::A_MAIN)) main_d <= bm(main_d, wdata, wstrb);
    end
  end

endmodule : fdc_core

// >>> design/fdc_pkg.sv
// Shared constants of the floating-point signal processor core.
package fdc_pkg;
  localparam int XW  = 32;
  localparam int WW  = 55;
  localparam int MW  = 47;
  localparam int EW  = 8;
  localparam int FW  = 24;
  localparam int RAW = 9;
  localparam int PAW = 11;
  localparam int IAW = 16;
  localparam int EAW = 24;
  localparam int SWW = 22;
  localparam int AW  = 8;
  localparam int CW  = 10;
  localparam logic [4:0]  PS_TOP  = 5'h1f;
  localparam logic [15:0] VEC_NMI = 16'h0004;
  localparam logic [15:0] VEC_INT = 16'h0008;
  localparam logic [7:0] A_RUN = 8'h00, A_STAT = 8'h04, A_CFG  = 8'h08, A_CNT  = 8'h0c;
  localparam logic [7:0] A_K   = 8'h10, A_L    = 8'h14, A_PRD  = 8'h18, A_MAIN = 8'h1c;
  localparam logic [7:0] A_EPT = 8'h20, A_FLG  = 8'h24, A_PTR0 = 8'h28, A_PTR1 = 8'h2c;
  localparam logic [7:0] A_PSA = 8'h30, A_PSD  = 8'h34, A_ASEL = 8'h38, A_ACCL = 8'h3c;
  localparam logic [7:0] A_ACCH = 8'h40, A_PC  = 8'h44;
  localparam int ST_IE = 0, ST_IL = 1, ST_GP = 2, ST_ERR = 4, ST_DONE = 5;
  localparam int CF_M0 = 0, CF_MOD0 = 4, CF_FIX = 12, CF_FSEL = 13, CF_SHV = 14, CF_MV = 20;
  localparam int IF_FN = 28, IF_PS = 25, IF_Q = 22, IF_P0 = 19, IF_LD = 15, IF_KL = 14;
  localparam int IF_IC = 12, IF_FT = 11, IF_EX = 9, IF_S0 = 8, IF_BG = 22, IF_BV = 21;
  localparam logic [3:0] FN_NOP = 4'h0, FN_INC = 4'h1, FN_DEC = 4'h2, FN_NOT = 4'h3;
  localparam logic [3:0] FN_NEG = 4'h4, FN_ADD = 4'h5, FN_SUB = 4'h6, FN_AND = 4'h7;
  localparam logic [3:0] FN_OR  = 4'h8, FN_XOR = 4'h9, FN_SHL = 4'ha, FN_SHR = 4'hb;
  localparam logic [3:0] FN_ADDF = 4'hc, FN_BR = 4'hf;
  localparam logic [2:0] PS_WIDE = 3'h0, PS_MAIN = 3'h1, PS_RAM0 = 3'h2, PS_RAM1 = 3'h3;
  localparam logic [2:0] PS_PROD = 3'h4;
  localparam logic [2:0] PT_BINC = 3'h1, PT_BDEC = 3'h2, PT_BCLR = 3'h3, PT_IINC = 3'h4;
  localparam logic [2:0] PT_IDEC = 3'h5, PT_ICLR = 3'h6, PT_IADD = 3'h7;
  localparam logic [1:0] AM_IDX = 2'h1, AM_SUM = 2'h2;
  localparam logic [1:0] IC_EN = 2'h1, IC_DIS = 2'h2, IC_DROP = 2'h3;
  localparam logic [1:0] EX_RD = 2'h1, EX_WR = 2'h2, EX_INC = 2'h3;
  localparam logic [1:0] RESP_OK = 2'h0, RESP_ERR = 2'h2;
  localparam logic [31:0] CFG_RST = 32'h0;
endpackage : fdc_pkg

// >>> verification/fdc_core_chk.sv
// Concurrent checks on the core's bus handshakes and external strobes.
`timescale 1ns/10ps
module fdc_core_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic ext_oe_n,
  input wire logic ext_re_n,
  input wire logic ext_we_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  chk_aw_answer: assert property (awready |=> !awready && bvalid)
    else $error("write answer late");
  chk_aw_pair: assert property (awready |-> wready)
    else $error("write channels split");
  chk_b_drop: assert property (bvalid && bready |=> !bvalid)
    else $error("write response stuck");
  chk_b_block: assert property (bvalid |-> !awready)
    else $error("write taken during response");
  chk_ar_answer: assert property (arready |=> !arready && rvalid)
    else $error("read answer late");
  chk_r_drop: assert property (rvalid && rready |=> !rvalid)
    else $error("read response stuck");
  chk_we_drive: assert property (!ext_we_n |-> !ext_oe_n)
    else $error("write strobe without drive");
  chk_ext_excl: assert property (!ext_re_n |-> ext_we_n)
    else $error("read and write strobes together");
  cover property (awready && wready);
  cover property (arready);
  cover property (!ext_we_n);
  cover property (!ext_re_n);
endmodule : fdc_core_chk

bind fdc_core fdc_core_chk u_chk (.aclk(aclk), .aresetn(aresetn), .awready(awready),
  .wready(wready), .bvalid(bvalid), .bready(bready), .arready(arready), .rvalid(rvalid),
  .rready(rready), .ext_oe_n(ext_oe_n), .ext_re_n(ext_re_n), .ext_we_n(ext_we_n));

// >>> verification/fdc_mem_model.sv
// Instruction memory and external data RAM seen by the core.
`timescale 1ns/10ps
module fdc_mem_model (
  input wire logic        aclk,
  output logic     [31:0] instr_data,
  input wire logic [23:0] ext_addr,
  input wire logic [31:0] ext_dout,
  input wire logic        ext_re_n,
  input wire logic        ext_we_n,
  output logic     [31:0] ext_din
);
  // Every address holds the same word, so a stopped and restarted PC still fetches it.
  logic [31:0] op = 32'h0;
  logic [31:0] ram [16];
  always @(posedge aclk) begin
    instr_data <= op;
    if (!ext_we_n)
      ram[ext_addr[3:0]] <= ext_dout;
  end
  // Outside a read the bus shows inverted data, so a stale capture cannot pass.
  assign ext_din = !ext_re_n ? ram[ext_addr[3:0]] : ~ram[ext_addr[3:0]];
endmodule : fdc_mem_model

// >>> verification/testbench.sv
// Self-checking bench for the signal processor core.
`timescale 1ns/10ps
module testbench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic int_n = 1, nmi_n = 1, awready, wready, bvalid, arready, rvalid, ext_oe_n, ext_re_n;
  logic ext_we_n;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] gp_in = 2'h0, bresp, rresp, gp_out;
  logic [31:0] wdata = 32'h0, rdata, instr_data, ext_dout, ext_din, rnd = 32'h1bc78892;
  logic [15:0] instr_addr;
  logic [23:0] ext_addr;
  int errors = 0, compares = 0, cyc = 0;
  localparam logic [7:0] ADR [4] = '{fdc_pkg::A_K, fdc_pkg::A_L, fdc_pkg::A_CNT, fdc_pkg::A_CFG};
  localparam logic [31:0] MSK [4] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h001fffff};
  fdc_core #(.RAM_DEPTH(512), .PS_DEPTH(2048)) DUT (.aclk, .aresetn, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready, .rdata, .rresp, .instr_addr, .instr_data, .ext_addr, .ext_din,
    .ext_dout, .ext_oe_n, .ext_re_n, .ext_we_n, .int_n, .nmi_n, .gp_in, .gp_out);
  fdc_mem_model mem (.aclk, .instr_data, .ext_addr, .ext_dout, .ext_re_n, .ext_we_n, .ext_din);
  initial forever #25 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    do @(negedge aclk); while (awready !== 1'b1);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do @(negedge aclk); while (bvalid !== 1'b1);
    check({30'h0, bresp}, {30'h0, er});
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= a;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(negedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    check({30'h0, rresp}, {30'h0, er});
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  task automatic run(input logic [31:0] op);
    mem.op <= op;
    wr(fdc_pkg::A_RUN, 32'h1, fdc_pkg::RESP_OK);
    repeat (8) @(posedge aclk);
    wr(fdc_pkg::A_RUN, 32'h0, fdc_pkg::RESP_OK);
  endtask : run
  task automatic wrap_up();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  // The whole sequence needs well under two thousand cycles.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    logic [31:0] v, w;
    logic [31:0] exp_q [$];
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check({30'h0, gp_out, ext_we_n, ext_re_n}, 32'h3);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      exp_q.push_back(rnd & MSK[i]);
      wr(ADR[i], rnd & MSK[i], fdc_pkg::RESP_OK);
    end
    for (int i = 0; i < 4; i++) begin
      rd(ADR[i], v, fdc_pkg::RESP_OK);
      check(v, exp_q.pop_front());
    end
    wr(8'h80, rnd, fdc_pkg::RESP_ERR);
    rd(8'h80, v, fdc_pkg::RESP_ERR);
    check(v, 32'h0);
    $display("test registers done");
    wr(fdc_pkg::A_STAT, 32'hc, fdc_pkg::RESP_OK);
    @(negedge aclk);
    check({30'h0, gp_out}, 32'h3);
    rd(fdc_pkg::A_STAT, v, fdc_pkg::RESP_OK);
    check(v, 32'hc);
    $display("test status done");
    wr(fdc_pkg::A_K, 32'h3, fdc_pkg::RESP_OK);
    wr(fdc_pkg::A_L, 32'h5, fdc_pkg::RESP_OK);
    wr(fdc_pkg::A_CFG, 32'h00101000, fdc_pkg::RESP_OK);
    wr(fdc_pkg::A_RUN, 32'h1, fdc_pkg::RESP_OK);
    repeat (4) @(posedge aclk);
    rd(fdc_pkg::A_PRD, v, fdc_pkg::RESP_OK);
    check(v, 3 * 5);
    int_n <= 1'b0;
    repeat (4) @(posedge aclk);
    int_n <= 1'b1;
    repeat (6) @(posedge aclk);
    rd(fdc_pkg::A_STAT, v, fdc_pkg::RESP_OK);
    check(v, 32'he);
    nmi_n <= 1'b0;
    repeat (4) @(posedge aclk);
    nmi_n <= 1'b1;
    for (int n = 0; n < 20 && instr_addr !== 16'h4; n++) @(negedge aclk);
    check({16'h0, instr_addr}, 32'h4);
    wr(fdc_pkg::A_RUN, 32'h0, fdc_pkg::RESP_OK);
    $display("test multiplier and interrupts done");
    v = lfsr(rnd);
    wr(fdc_pkg::A_MAIN, v, fdc_pkg::RESP_OK);
    wr(fdc_pkg::A_EPT, 32'h00800005, fdc_pkg::RESP_OK);
    run(32'h400);
    check(mem.ram[5], v);
    check({8'h0, ext_addr}, 32'h00800005);
    w = lfsr(v);
    mem.ram[6] <= w;
    wr(fdc_pkg::A_EPT, 32'h6, fdc_pkg::RESP_OK);
    run(32'h200);
    rd(fdc_pkg::A_MAIN, v, fdc_pkg::RESP_OK);
    check(v, w);
    rd(fdc_pkg::A_STAT, v, fdc_pkg::RESP_OK);
    check(v & 32'h20, 32'h20);
    $display("test external memory done");
    wr(fdc_pkg::A_CNT, 32'hfffffc05, fdc_pkg::RESP_OK);
    run(32'h8000);
    rd(fdc_pkg::A_CNT, v, fdc_pkg::RESP_OK);
    check(v & 32'hfffffc00, 32'hfffffc00);
    check({31'h0, v[9:0] == 10'h5}, 32'h0);
    $display("test counter done");
    wrap_up();
  end
endmodule : testbench
